// *** inc/hsc_pkg.sv ***
// Purpose: constants and types for the hub strap capture and config select
// Assumes: one 100 MHz clock, asynchronous active-low chip reset
// Notes:   register offsets are byte addresses of 32-bit words
//
// What this block does
// R1 - port power output active level follows the polarity strap
// R2 - led enabled by eeprom or smbus config drives green leds active low
// R3 - default mode samples the two led/fixed-port straps at reset release
// R4 - fixed-port strap 00 none, 01 port 1, 10/11 ports 1 and 2 fixed
// R5 - strap sets led polarity: bit0 port 1 active low, bit1 port 2
// R6 - during reset port power shows inactive level from live polarity strap
// R7 - polarity strap latched at reset release and used afterwards
// R8 - polarity strap 1 means active high, 0 means active low
// R9 - over-current sense input, active low, flags over-current
// R10 - both config select inputs sampled at reset release
// R11 - select code 01 makes an smbus slave at address 0101100
// R12 - code 10 internal defaults with straps, 11 eeprom, 00 reserved
// R13 - eeprom selected but absent loads all-zero configuration
// R14 - captured straps hold until the next chip reset
package hsc_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // register offsets
   localparam logic [7:0] OFS_STRAP   = 8'h00;
   localparam logic [7:0] OFS_CONFIG  = 8'h04;
   localparam logic [7:0] OFS_IRQ_STS = 8'h08;
   localparam logic [7:0] OFS_IRQ_MSK = 8'h0c;
   localparam logic [7:0] OFS_LIVE    = 8'h10;

   // config register fields
   localparam int CFG_LED_EN = 0;
   localparam int CFG_NR_LSB = 1;
   localparam int CFG_W      = 3;
   localparam logic [2:0] CFG_RESET = 3'h0;

   // irq status bits
   localparam int IRQ_OC_SET  = 0;
   localparam int IRQ_OC_CLR  = 1;
   localparam int IRQ_EE_MISS = 2;
   localparam int IRQ_W       = 3;
   localparam logic [2:0] IRQ_RESET = 3'h0;

   // smbus slave address 0101100
   localparam logic [6:0] SMB_ADDR = 7'h2c;

   // fixed-port decode results
   localparam logic [1:0] NR_NONE  = 2'h0;
   localparam logic [1:0] NR_PORT1 = 2'h1;
   localparam logic [1:0] NR_BOTH  = 2'h3;

   typedef enum logic [1:0]
   {
      MODE_RESERVED = 2'h0,
      MODE_SMBUS    = 2'h1,
      MODE_DEFAULT  = 2'h2,
      MODE_EEPROM   = 2'h3
   } hsc_mode_e;

   typedef enum logic [1:0]
   {
      ST_CAPTURE = 2'h0,
      ST_LOAD    = 2'h1,
      ST_RUN     = 2'h3
   } hsc_state_e;

endpackage

// *** inc/hsc_strap_if.sv ***
`timescale 1ns/1ps
// Purpose: carries captured strap values from capture to control logic
// Assumes: values are valid only while valid is high
// Notes:   one producer, one consumer
interface hsc_strap_if;
   logic       valid;
   logic       pol;
   logic [1:0] fixed;
   logic [1:0] sel;

   modport cap
   (
      output valid,
      output pol,
      output fixed,
      output sel
   );

   modport use_side
   (
      input valid,
      input pol,
      input fixed,
      input sel
   );
endinterface

// *** sim/hsc_board_model.sv ***
// Purpose: board side of the hub: strap resistors, power switch, eeprom
// Assumes: bench sets strap values, fault and eeprom answer before reset
// Notes:   eeprom data lines carry a changing pattern outside the done cycle
`timescale 1ns/1ps
module hsc_board_model
   import hsc_pkg::*;
(
   // clock and reset
   input  wire logic       sys_clk_in,
   input  wire logic       rst_n_in,
   // bench settings
   input  wire logic [1:0] fixed_set_in,
   input  wire logic       oc_fault_in,
   input  wire logic       ee_present_in,
   input  wire logic [2:0] ee_cfg_in,
   input  wire logic [3:0] ee_delay_in,
   // from the hub
   input  wire logic [1:0] led_in,
   input  wire logic [1:0] led_oe_in,
   input  wire logic       ee_start_in,
   // towards the hub
   output      logic [1:0] fixed_pin_out,
   output      logic       oc_n_out,
   output      logic       ee_done_out,
   output      logic       ee_present_out,
   output      logic [2:0] ee_cfg_out
);
   logic [3:0] wait_q;
   logic       busy_q;

   ////////////////////////////////////////////////////////////////////////
   // shared led pin: hub drive wins per bit, else the strap resistor
   assign fixed_pin_out = (led_oe_in & led_in) | (~led_oe_in & fixed_set_in);
   // current monitor pulls the sense line low on a fault
   assign oc_n_out = ~oc_fault_in;

   ////////////////////////////////////////////////////////////////////////
   // eeprom engine: answers one load after a set delay
   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         busy_q         <= 1'b0;
         wait_q         <= 4'h0;
         ee_done_out    <= 1'b0;
         ee_present_out <= 1'b0;
         ee_cfg_out     <= 3'h5;
      end
      else
      begin
         ee_done_out    <= 1'b0;
         ee_present_out <= ~ee_present_out;
         ee_cfg_out     <= ~ee_cfg_out;
         if (ee_start_in)
         begin
            busy_q <= 1'b1;
            wait_q <= ee_delay_in;
         end
         else if (busy_q && wait_q != 4'h0)
            wait_q <= wait_q - 4'h1;
         else if (busy_q)
         begin
            busy_q         <= 1'b0;
            ee_done_out    <= 1'b1;
            ee_present_out <= ee_present_in;
            if (ee_present_in)
               ee_cfg_out <= ee_cfg_in;
         end
      end
   end
endmodule

// *** sim/hsc_strap_top_tb.sv ***
// Purpose: self-checking bench for strap capture and config select
// Assumes: register port answers one cycle after a read strobe
// Notes:   each test starts with a chip reset carrying its own straps
`timescale 1ns/1ps
module hsc_strap_top_tb
   import hsc_pkg::*;
   ;
   logic        sys_clk, rst_n, pol, oc_fault, ee_pres_set, pwr_req, rd_s, wr_s;
   logic [1:0]  fixed_set, sel, led_req, nr, led, led_oe, fixed_pin;
   logic [2:0]  ee_cfg_set, ee_cfg;
   logic [3:0]  ee_delay;
   logic [6:0]  smb_addr;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata;
   logic        pwr_en, ready, oc, smb_en, ee_start, ee_done, ee_pres;
   logic        oc_n, irq;
   int          failures, check_count;

   ////////////////////////////////////////////////////////////////////////
   hsc_board_model u_hsc_board_model
   (
      .sys_clk_in(sys_clk), .rst_n_in(rst_n), .fixed_set_in(fixed_set),
      .oc_fault_in(oc_fault), .ee_present_in(ee_pres_set),
      .ee_cfg_in(ee_cfg_set), .ee_delay_in(ee_delay), .led_in(led),
      .led_oe_in(led_oe), .ee_start_in(ee_start), .fixed_pin_out(fixed_pin),
      .oc_n_out(oc_n), .ee_done_out(ee_done), .ee_present_out(ee_pres),
      .ee_cfg_out(ee_cfg)
   );
   hsc_strap_top u_hsc_strap_top
   (
      .sys_clk_in(sys_clk), .rst_n_in(rst_n),
      .port_power_polarity_strap_in(pol), .fixed_port_strap_in(fixed_pin),
      .config_source_select_lo_in(sel[0]),
      .config_source_select_hi_in(sel[1]),
      .overcurrent_in_n_in(oc_n), .port_power_enable_out(pwr_en),
      .port_power_request_in(pwr_req), .port_led_request_in(led_req),
      .nonremovable_ports_out(nr), .config_ready_out(ready),
      .overcurrent_out(oc), .port_green_led_out(led),
      .port_green_led_oe_out(led_oe), .smbus_slave_enable_out(smb_en),
      .smbus_slave_addr_out(smb_addr), .eeprom_load_start_out(ee_start),
      .eeprom_load_done_in(ee_done), .eeprom_present_in(ee_pres),
      .eeprom_cfg_in(ee_cfg), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata),
      .irq_out(irq)
   );

   always #5 sys_clk = ~sys_clk;

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string m);
      check_count++;
      if (got !== exp)
      begin
         failures++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic reg_rd(input logic [7:0] a, input logic [31:0] e,
                         input string m);
      @(posedge sys_clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge sys_clk);
      rd_s <= 1'b0;
      #1 chk(rdata, e, m);
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      addr  <= a;
      wdata <= d;
      wr_s  <= 1'b1;
      @(posedge sys_clk);
      wr_s <= 1'b0;
   endtask

   task automatic do_reset(input logic p, input logic [1:0] f,
                           input logic [1:0] s, input logic ep,
                           input logic [2:0] ec, input logic [3:0] ed);
      int n;
      @(posedge sys_clk);
      rst_n       <= 1'b0;
      pol         <= p;
      fixed_set   <= f;
      sel         <= s;
      ee_pres_set <= ep;
      ee_cfg_set  <= ec;
      ee_delay    <= ed;
      pwr_req     <= 1'b0;
      led_req     <= 2'h0;
      oc_fault    <= 1'b0;
      cyc(5);
      chk(32'(pwr_en), 32'(!p), "power off in reset");
      @(posedge sys_clk);
      rst_n <= 1'b1;
      n = 0;
      while (ready !== 1'b1 && n < 40)
      begin
         @(posedge sys_clk);
         n++;
      end
      #1 chk(32'(ready), 32'h1, "config ready");
   endtask

   task automatic end_test(input string m);
      $display("test %s done", m);
   endtask

   task automatic wrap_up;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      #100us;
      failures++;
      wrap_up();
   end

   initial
   begin
      logic       p;
      logic [1:0] f;
      logic [1:0] e;
      sys_clk = 1'b0; rst_n = 1'b0; pol = 1'b0; oc_fault = 1'b0;
      ee_pres_set = 1'b0; pwr_req = 1'b0; rd_s = 1'b0; wr_s = 1'b0;
      fixed_set = 2'h0; sel = 2'h0; led_req = 2'h0; ee_cfg_set = 3'h0;
      ee_delay = 4'h0; addr = 8'h00; wdata = 32'h0;
      failures = 0; check_count = 0;
      for (int i = 0; i < 8; i++)
      begin
         p = i[2];
         f = 2'(i);
         e = (f == 2'h0) ? NR_NONE : (f == 2'h1) ? NR_PORT1 : NR_BOTH;
         do_reset(p, f, 2'h2, 1'b0, 3'h0, 4'h0);
         reg_rd(OFS_STRAP, {23'h0, 2'h3, 4'ha, f, p}, "strap");
         chk(32'(nr), 32'(e), "fixed ports");
         chk(32'(pwr_en), 32'(!p), "power idle");
         @(posedge sys_clk);
         led_req <= 2'h1;
         pwr_req <= 1'b1;
         pol     <= ~p;
         cyc(3);
         chk(32'(led), 32'(2'h1 ^ f), "led level");
         chk(32'(led_oe), 32'h3, "led drive");
         chk(32'(pwr_en), 32'(p), "power on");
         reg_rd(OFS_STRAP, {23'h0, 2'h3, 4'ha, f, p}, "strap hold");
      end
      end_test("default straps");
      do_reset(1'b1, 2'h0, 2'h1, 1'b0, 3'h0, 4'h0);
      chk(32'(smb_en), 32'h1, "smbus mode");
      chk(32'(smb_addr), 32'h2c, "smbus address");
      reg_wr(OFS_CONFIG, 32'h7);
      reg_rd(OFS_CONFIG, 32'h7, "config write");
      @(posedge sys_clk);
      led_req <= 2'h1;
      cyc(3);
      chk(32'(nr), 32'h3, "smbus fixed ports");
      chk(32'(led), 32'h2, "led active low");
      chk(32'(led_oe), 32'h3, "led enabled");
      end_test("smbus");
      do_reset(1'b1, 2'h3, 2'h0, 1'b1, 3'h7, 4'h2);
      chk(32'(smb_en), 32'h0, "reserved no smbus");
      reg_wr(OFS_CONFIG, 32'h7);
      reg_rd(OFS_CONFIG, 32'h0, "reserved config");
      chk(32'(led_oe), 32'h0, "reserved leds");
      end_test("reserved");
      do_reset(1'b0, 2'h0, 2'h3, 1'b1, 3'h5, 4'h9);
      reg_rd(OFS_CONFIG, 32'h5, "eeprom config");
      chk(32'(nr), 32'h2, "eeprom fixed ports");
      chk(32'(smb_en), 32'h0, "eeprom no smbus");
      end_test("eeprom present");
      do_reset(1'b0, 2'h3, 2'h3, 1'b0, 3'h7, 4'h0);
      reg_rd(OFS_CONFIG, 32'h0, "absent config");
      chk(32'(nr), 32'h0, "absent fixed ports");
      chk(32'(led_oe), 32'h0, "absent leds");
      reg_rd(OFS_IRQ_STS, 32'h4, "missing flag");
      chk(32'(irq), 32'h0, "irq masked");
      reg_wr(OFS_IRQ_MSK, 32'h4);
      cyc(2);
      chk(32'(irq), 32'h1, "irq raised");
      @(posedge sys_clk);
      oc_fault <= 1'b1;
      cyc(3);
      chk(32'(oc), 32'h1, "over-current seen");
      reg_rd(OFS_IRQ_STS, 32'h5, "oc set flag");
      @(posedge sys_clk);
      oc_fault <= 1'b0;
      cyc(3);
      chk(32'(oc), 32'h0, "over-current gone");
      reg_rd(OFS_IRQ_STS, 32'h7, "oc clear flag");
      reg_wr(OFS_IRQ_STS, 32'h4);
      cyc(2);
      chk(32'(irq), 32'h0, "irq cleared");
      reg_rd(OFS_IRQ_STS, 32'h3, "status after clear");
      reg_rd(OFS_IRQ_MSK, 32'h4, "mask readback");
      reg_rd(8'h14, 32'h0, "unmapped read");
      end_test("eeprom absent and irq");
      wrap_up();
   end
endmodule

// *** verilog/hsc_strap_capture.sv ***
`timescale 1ns/1ps
// Purpose: catches all straps once after chip reset release
// Assumes: strap pins are steady around reset release
// Notes:   later pin activity is ignored until the next reset
module hsc_strap_capture
   import hsc_pkg::*;
(
   // clock and reset
   input  wire logic       sys_clk_in,
   input  wire logic       rst_n_in,
   // live strap pins
   input  wire logic       pol_in,
   input  wire logic [1:0] fixed_in,
   input  wire logic [1:0] sel_in,
   // captured values
   hsc_strap_if.cap        strap_out
);

   typedef struct packed
   {
      logic       valid;
      logic       pol;
      logic [1:0] fixed;
      logic [1:0] sel;
   } hsc_cap_s;

   hsc_cap_s cap_q;
   hsc_cap_s cap_d;

   always_comb
   begin
      cap_d = cap_q;
      if (!cap_q.valid) // R14
      begin
         cap_d.valid = 1'b1;
         cap_d.pol   = pol_in;   // R7
         cap_d.fixed = fixed_in; // R3
         cap_d.sel   = sel_in;   // R10
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         cap_q <= '0;
      else
         cap_q <= cap_d;
   end

   assign strap_out.valid = cap_q.valid;
   assign strap_out.pol   = cap_q.pol;
   assign strap_out.fixed = cap_q.fixed;
   assign strap_out.sel   = cap_q.sel;

   ////////////////////////////////////////////////////////////////////////
   AST_STRAP_TAKE: assert property ( // R10
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      rst_n_in && !cap_q.valid |=> cap_q.valid
         && cap_q.sel == $past(sel_in)
         && cap_q.pol == $past(pol_in) && cap_q.fixed == $past(fixed_in))
      else $error("straps not taken at reset release");

   AST_STRAP_HELD: assert property ( // R14
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      cap_q.valid |=> cap_q.valid && $stable(cap_q))
      else $error("captured straps changed after capture");

endmodule

// *** verilog/hsc_strap_top.sv ***
`timescale 1ns/1ps
// Purpose: strap capture, config source select, port power and led pins
// Assumes: pins synchronous to sys_clk_in; hub engine asks power and leds
// Notes:   port power output is combinational so it is safe in reset
module hsc_strap_top
   import hsc_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk_in,
   input  wire logic        rst_n_in,
   // strap pins
   input  wire logic        port_power_polarity_strap_in,
   input  wire logic [1:0]  fixed_port_strap_in,
   input  wire logic        config_source_select_lo_in,
   input  wire logic        config_source_select_hi_in,
   // power switch
   input  wire logic        overcurrent_in_n_in,
   output      logic        port_power_enable_out,
   // hub engine
   input  wire logic        port_power_request_in,
   input  wire logic [1:0]  port_led_request_in,
   output      logic [1:0]  nonremovable_ports_out,
   output      logic        config_ready_out,
   output      logic        overcurrent_out,
   // green led pins, shared with fixed-port straps
   output      logic [1:0]  port_green_led_out,
   output      logic [1:0]  port_green_led_oe_out,
   // serial config engines
   output      logic        smbus_slave_enable_out,
   output      logic [6:0]  smbus_slave_addr_out,
   output      logic        eeprom_load_start_out,
   input  wire logic        eeprom_load_done_in,
   input  wire logic        eeprom_present_in,
   input  wire logic [2:0]  eeprom_cfg_in,
   // register port
   input  wire logic [7:0]  reg_addr_in,
   input  wire logic [31:0] reg_wdata_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   output      logic [31:0] reg_rdata_out,
   output      logic        irq_out
);

   ////////////////////////////////////////////////////////////////////////
   // decode helpers

   function automatic logic [1:0] nr_decode(input logic [1:0] s);
      logic [1:0] r;
      r = NR_BOTH;
      if (s == 2'h0)
         r = NR_NONE;
      else if (s == 2'h1)
         r = NR_PORT1;
      return r;
   endfunction

   function automatic hsc_mode_e mode_decode(input logic [1:0] s);
      hsc_mode_e m;
      m = hsc_mode_e'(s);
      return m;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // strap capture

   hsc_strap_if strap ();

   hsc_strap_capture u_cap
   (
      .sys_clk_in (sys_clk_in),
      .rst_n_in   (rst_n_in),
      .pol_in     (port_power_polarity_strap_in),
      .fixed_in   (fixed_port_strap_in),
      .sel_in     ({config_source_select_hi_in, config_source_select_lo_in}),
      .strap_out  (strap)
   );

   ////////////////////////////////////////////////////////////////////////
   // state

   typedef struct packed
   {
      hsc_state_e  st;
      hsc_mode_e   mode;
      logic [2:0]  cfg;
      logic [2:0]  sts;
      logic [2:0]  msk;
      logic        oc;
      logic        pwr;
      logic [1:0]  nr;
      logic [1:0]  led;
      logic [1:0]  led_oe;
      logic        smb_en;
      logic [6:0]  smb_addr;
      logic        ee_start;
      logic        ready;
      logic        irq;
      logic [31:0] rdata;
   } hsc_top_s;

   hsc_top_s r_q;
   hsc_top_s r_d;

   logic       pol_eff;
   logic       wr_cfg;
   logic       wr_sts;
   logic [2:0] ev;
   logic [1:0] led_low;

   ////////////////////////////////////////////////////////////////////////
   // next state

   always_comb
   begin
      r_d      = r_q;
      ev       = 3'h0;
      led_low  = 2'h3;
      wr_cfg   = reg_wr_in && reg_addr_in == OFS_CONFIG;
      wr_sts   = reg_wr_in && reg_addr_in == OFS_IRQ_STS;
      r_d.ee_start = 1'b0;

      // over-current sense, active low
      r_d.oc = !overcurrent_in_n_in; // R9
      ev[IRQ_OC_SET] = !overcurrent_in_n_in && !r_q.oc;
      ev[IRQ_OC_CLR] = overcurrent_in_n_in && r_q.oc;

      unique case (r_q.st)
         ST_CAPTURE:
         begin
            if (strap.valid)
            begin
               r_d.mode = mode_decode(strap.sel); // R10
               unique case (mode_decode(strap.sel))
                  MODE_EEPROM:
                  begin
                     r_d.st       = ST_LOAD;
                     r_d.ee_start = 1'b1;
                  end
                  MODE_SMBUS:
                  begin
                     r_d.smb_en   = 1'b1;     // R11
                     r_d.smb_addr = SMB_ADDR; // R11
                     r_d.st       = ST_RUN;
                  end
                  MODE_DEFAULT:
                  begin
                     r_d.nr = nr_decode(strap.fixed); // R4
                     r_d.st = ST_RUN;
                  end
                  MODE_RESERVED:
                  begin
                     r_d.cfg = CFG_RESET; // R12
                     r_d.st  = ST_RUN;
                  end
               endcase
            end
         end
         ST_LOAD:
         begin
            if (eeprom_load_done_in)
            begin
               r_d.st = ST_RUN;
               if (eeprom_present_in)
                  r_d.cfg = eeprom_cfg_in;
               else
               begin
                  r_d.cfg = CFG_RESET; // R13
                  ev[IRQ_EE_MISS] = 1'b1;
               end
            end
         end
         ST_RUN:
         begin
            r_d.ready = 1'b1;
         end
         default:
         begin
            r_d.st = ST_CAPTURE;
         end
      endcase

      // smbus host downloads config through the register port
      if (wr_cfg && r_q.mode == MODE_SMBUS)
         r_d.cfg = reg_wdata_in[CFG_W-1:0];
      if (r_d.mode != MODE_DEFAULT)
         r_d.nr = r_d.cfg[CFG_NR_LSB +: 2];

      if (reg_wr_in && reg_addr_in == OFS_IRQ_MSK)
         r_d.msk = reg_wdata_in[IRQ_W-1:0];

      // write one to clear; a new event wins over the clear
      r_d.sts = (r_q.sts & ~(wr_sts ? reg_wdata_in[IRQ_W-1:0] : 3'h0)) | ev;
      r_d.irq = |(r_d.sts & r_d.msk);

      // port power request, only once configured
      r_d.pwr = port_power_request_in && r_q.st == ST_RUN;

      // green leds: strap polarity in default mode, else active low
      if (r_q.mode == MODE_DEFAULT)
      begin
         led_low = strap.fixed; // R5
         r_d.led_oe = {2{r_q.st == ST_RUN}};
      end
      else
      begin
         r_d.led_oe = {2{r_q.st == ST_RUN && r_q.cfg[CFG_LED_EN]}}; // R2
      end
      r_d.led = port_led_request_in ^ led_low; // R2

      // read data stand for one cycle only
      r_d.rdata = 32'h0;
      if (reg_rd_in)
      begin
         unique case (reg_addr_in)
            OFS_STRAP:
               r_d.rdata = {23'h0, r_q.st, r_q.mode, strap.sel,
                            strap.fixed, strap.pol};
            OFS_CONFIG:
               r_d.rdata = {29'h0, r_q.cfg};
            OFS_IRQ_STS:
               r_d.rdata = {29'h0, r_q.sts};
            OFS_IRQ_MSK:
               r_d.rdata = {29'h0, r_q.msk};
            OFS_LIVE:
               r_d.rdata = {27'h0, r_q.ready, r_q.oc, r_q.pwr, r_q.nr};
            default:
               r_d.rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         r_q      <= '0;
         r_q.st   <= ST_CAPTURE;
         r_q.mode <= MODE_RESERVED;
         r_q.cfg  <= CFG_RESET;
         r_q.sts  <= IRQ_RESET;
         r_q.msk  <= IRQ_RESET;
      end
      else
         r_q <= r_d;
   end

   ////////////////////////////////////////////////////////////////////////
   // port power: live strap in reset, latched strap afterwards

   assign pol_eff = strap.valid ? strap.pol : port_power_polarity_strap_in;

   always_comb
   begin
      if (!rst_n_in)
         port_power_enable_out = !port_power_polarity_strap_in; // R6
      else if (pol_eff)
         port_power_enable_out = r_q.pwr;  // R8
      else
         port_power_enable_out = !r_q.pwr; // R1
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   assign nonremovable_ports_out = r_q.nr;
   assign config_ready_out       = r_q.ready;
   assign overcurrent_out        = r_q.oc;
   assign port_green_led_out     = r_q.led;
   assign port_green_led_oe_out  = r_q.led_oe;
   assign smbus_slave_enable_out = r_q.smb_en;
   assign smbus_slave_addr_out   = r_q.smb_addr;
   assign eeprom_load_start_out  = r_q.ee_start;
   assign reg_rdata_out          = r_q.rdata;
   assign irq_out                = r_q.irq;

   ////////////////////////////////////////////////////////////////////////
   // checks

   always_comb
   begin
      if (!rst_n_in)
         AST_RESET_OFF: assert (port_power_enable_out == // R6
            !port_power_polarity_strap_in)
            else $error("port power active during reset");
   end

   AST_PWR_POL: assert property ( // R8
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      strap.valid |-> port_power_enable_out == (strap.pol ~^ r_q.pwr))
      else $error("port power level ignores latched polarity");

   AST_PWR_LATCH: assert property ( // R7
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      strap.valid && !r_q.pwr && $changed(port_power_polarity_strap_in)
         |-> port_power_enable_out == !strap.pol)
      else $error("port power follows live strap after reset");

   AST_MODE_SEL: assert property ( // R10
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      r_q.st == ST_CAPTURE && strap.valid
         |=> r_q.mode == mode_decode($past(strap.sel)))
      else $error("config mode does not match select straps");

   AST_SMB_ADDR: assert property ( // R11
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      r_q.st == ST_RUN && r_q.mode == MODE_SMBUS
         |-> smbus_slave_enable_out && smbus_slave_addr_out == 7'h2c)
      else $error("smbus slave not enabled at its address");

   AST_EE_START: assert property ( // R12
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      r_q.st == ST_CAPTURE && strap.valid && strap.sel == 2'h3
         |=> eeprom_load_start_out ##1 !eeprom_load_start_out)
      else $error("eeprom load not started for one cycle");

   AST_EE_ZERO: assert property ( // R13
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      r_q.st == ST_LOAD && eeprom_load_done_in && !eeprom_present_in
         |=> r_q.cfg == 3'h0 && r_q.st == ST_RUN ##1 irq_out == r_q.msk[2])
      else $error("absent eeprom did not load zero config");

   AST_NONREM: assert property ( // R4
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      r_q.st == ST_RUN && r_q.mode == MODE_DEFAULT
         |-> nonremovable_ports_out
            == {strap.fixed[1], strap.fixed[1] | strap.fixed[0]})
      else $error("fixed-port decode wrong");

   AST_LED_POL: assert property ( // R5
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      r_q.st == ST_RUN && r_q.mode == MODE_DEFAULT
         |=> port_green_led_out == ($past(port_led_request_in) ^ strap.fixed))
      else $error("default-mode led polarity wrong");

   AST_LED_LOW: assert property ( // R2
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      r_q.st == ST_RUN && r_q.mode != MODE_DEFAULT && r_q.cfg[0]
         |=> port_green_led_oe_out == 2'h3
            && port_green_led_out == ~$past(port_led_request_in))
      else $error("configured leds not active low");

   AST_OC_FLAG: assert property ( // R9
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      $fell(overcurrent_in_n_in) |=> r_q.sts[0] && overcurrent_out)
      else $error("over-current not flagged");

endmodule
